// [bccd_pkg.sv]
// Shared constants and types for the condition and data-compare block
package bccd_pkg;

    // ********************************************************
    // Opcodes and condition codes
    // ********************************************************
    localparam logic [4:0] OP_LOAD_MASK = 5'h04;
    localparam logic [4:0] OP_LOAD_GOAL = 5'h05;
    localparam logic [4:0] OP_FETCH_WORD = 5'h06;
    localparam logic [4:0] OP_RATE_LOAD = 5'h07;
    localparam logic [4:0] OP_JUMP_DATA = 5'h08;
    localparam logic [4:0] OP_CMP_FRAME = 5'h0a;
    localparam logic [4:0] OP_CMP_MSG = 5'h0b;
    localparam logic [4:0] OP_FLAG_WRITE = 5'h0c;

    localparam int COND_INV_BIT = 4;
    localparam logic [3:0] COND_LESS = 4'h0;
    localparam logic [3:0] COND_EQUAL = 4'h1;
    localparam logic [3:0] COND_RT_TMO = 4'h8;
    localparam logic [3:0] COND_RT_ERR = 4'h9;
    localparam logic [3:0] COND_GOOD_DATA = 4'ha;
    localparam logic [3:0] COND_STAT_SET = 4'hb;
    localparam logic [3:0] COND_BAD_MSG = 4'hc;
    localparam logic [3:0] COND_ONE_RETRY = 4'hd;
    localparam logic [3:0] COND_TWO_RETRY = 4'he;
    localparam logic [3:0] COND_TRUE = 4'hf;

    // ********************************************************
    // Register map, fields and reset values
    // ********************************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CFG4 = 8'h04;
    localparam logic [ADDR_W-1:0] REG_CFG5 = 8'h08;
    localparam logic [ADDR_W-1:0] REG_MASK = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_GOAL = 8'h10;
    localparam logic [ADDR_W-1:0] REG_FETCH = 8'h14;
    localparam logic [ADDR_W-1:0] REG_RATE = 8'h18;
    localparam int CFG4_BCST_BIT = 11;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [15:0] RATE_RST = 16'h0000;
    localparam logic [15:0] TMO_RST = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Received status word and control word mask positions
    localparam int SW_ME = 10;
    localparam int SW_SR = 8;
    localparam int SW_RSV_HI = 7;
    localparam int SW_RSV_LO = 5;
    localparam int SW_BCST = 4;
    localparam int SW_BUSY = 3;
    localparam int SW_SSF = 2;
    localparam int SW_TF = 0;
    localparam int CW_M_ME = 14;
    localparam int CW_M_SR = 13;
    localparam int CW_M_BUSY = 12;
    localparam int CW_M_SSF = 11;
    localparam int CW_M_TF = 10;
    localparam int CW_M_RSV = 9;
    localparam int CW_M_BCST = 5;

    // ********************************************************
    // Carriers
    // ********************************************************
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } bccd_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bccd_axi_rsp_t;

    typedef struct packed {
        logic valid;
        logic [4:0] opcode;
        logic [4:0] cond;
        logic [15:0] param;
    } bccd_instr_t;

    typedef struct packed {
        logic done;
        logic cond_met;
        logic branch;
        logic [15:0] target;
    } bccd_result_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } bccd_mem_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } bccd_mem_rsp_t;

    typedef struct packed {
        logic [15:0] rsp_time;
        logic no_rsp;
        logic err_sync;
        logic err_manch;
        logic err_parity;
        logic err_bitcnt;
        logic err_wcnt;
        logic err_addr;
        logic good_data;
        logic [15:0] stat_word;
        logic [15:0] ctrl_word;
        logic err_loop;
        logic err_format;
        logic [1:0] retries;
    } bccd_msg_stat_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_FETCH = 1'b1
    } bccd_fsm_t;

endpackage

// [bccd_core.sv]
// Condition evaluation and data-compare branching unit
//
// Summary of operation
// - Mask instruction loads mask used on both words
// - Goal instruction stores compare goal unconditionally
// - Fetch instruction reads memory word into register
// - Rate load sets dilution reload value
// - Data jump branches on condition and zero count
// - Data jump decrements count, reloads at zero
// - Dilution rate resets to zero
// - Flag 0 set when masked fetch below goal
// - Data jump tests equal flag, or flag 0
// - Code 0 is less-than or flag 0
// - Code 1 is equal or flag 1
// - Flags 0,1 written by instructions and host
// - Codes 2-7 test flags; bit 4 inverts
// - Code 8 is response timeout against config five
// - Code 9 is any link or address error
// - Code 0xA is valid data delivered
// - Code 11 is unmasked status bit, broadcast mode
// - Code 0xC is loopback, format or no response
// - Codes 0xD/0xE count one or two retries
// - Code 0xF is constant true
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
module bccd_core
    import bccd_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire bccd_axi_req_t axi_req_i,
    output bccd_axi_rsp_t axi_rsp_o,
    input wire bccd_instr_t instr_i,
    output logic instr_ready_o,
    output bccd_result_t result_o,
    output bccd_mem_req_t mem_req_o,
    input wire bccd_mem_rsp_t mem_rsp_i,
    input wire bccd_msg_stat_t msg_stat_i,
    input wire logic [15:0] frame_time_i,
    input wire logic [15:0] msg_time_i
);

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        bccd_fsm_t st;
        logic rdy;
        logic [7:0] flags;
        logic [15:0] mask;
        logic [15:0] goal;
        logic [15:0] fetched;
        logic [15:0] rate;
        logic [15:0] dil_cnt;
        logic bcst_mode;
        logic [15:0] tmo;
        bccd_result_t res;
        bccd_mem_req_t mreq;
        bccd_axi_rsp_t axi;
        logic aw_held;
        logic [ADDR_W-1:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
    } bccd_state_t;

    bccd_state_t q;
    bccd_state_t d;
    logic take;
    logic cond_now;
    logic [15:0] mfetch;
    logic [15:0] mgoal;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = data[7:0];
        end
        if (strb[1]) begin
            r[15:8] = data[15:8];
        end
        return r;
    endfunction

    // ********************************************************
    // Condition table
    // ********************************************************
    function automatic logic eval_cond(input logic [4:0] code,
                                       input logic [7:0] fl,
                                       input bccd_msg_stat_t m,
                                       input logic bmode,
                                       input logic [15:0] tmo);
        logic c;
        logic bc;
        logic [15:0] sw;
        logic [15:0] cw;
        sw = m.stat_word;
        cw = m.ctrl_word;
        // Mask mode ignores or forbids the bit; compare mode fires when it differs from the control bit
        bc = bmode ? (sw[SW_BCST] & ~cw[CW_M_BCST])
                   : (sw[SW_BCST] ^ cw[CW_M_BCST]);
        unique case (code[3:0])
            COND_RT_TMO: c = m.no_rsp | (m.rsp_time > tmo);
            COND_RT_ERR: c = m.err_sync | m.err_manch | m.err_parity
                           | m.err_bitcnt | m.err_wcnt
                           | m.err_addr;
            COND_GOOD_DATA: c = m.good_data;
            COND_STAT_SET: c = (sw[SW_ME] & ~cw[CW_M_ME])
                             | (sw[SW_SR] & ~cw[CW_M_SR])
                             | (sw[SW_BUSY] & ~cw[CW_M_BUSY])
                             | (sw[SW_SSF] & ~cw[CW_M_SSF])
                             | (sw[SW_TF] & ~cw[CW_M_TF])
                             | ((|sw[SW_RSV_HI:SW_RSV_LO])
                                & ~cw[CW_M_RSV])
                             | bc;
            COND_BAD_MSG: c = m.err_loop | m.err_format
                            | m.no_rsp;
            COND_ONE_RETRY: c = (m.retries == 2'h1);
            COND_TWO_RETRY: c = (m.retries == 2'h2);
            COND_TRUE: c = 1'b1;
            // Codes 0..7: the flag itself; less/equal live in 0 and 1
            default: c = fl[code[2:0]];
        endcase
        return code[COND_INV_BIT] ? ~c : c;
    endfunction

    assign take = instr_i.valid & q.rdy;
    assign cond_now = eval_cond(instr_i.cond, q.flags, msg_stat_i,
                                q.bcst_mode, q.tmo);
    assign mfetch = mem_rsp_i.data & q.mask;
    assign mgoal = q.goal & q.mask;

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        logic [31:0] rd;
        logic hit;
        rd = 32'h0000_0000;
        hit = 1'b1;
        d = q;
        d.res.done = 1'b0;
        d.res.branch = 1'b0;

        // Register writes, both halves collected in any order
        if (axi_req_i.awvalid && q.axi.awready) begin
            d.aw_held = 1'b1;
            d.awaddr = axi_req_i.awaddr;
        end
        if (axi_req_i.wvalid && q.axi.wready) begin
            d.w_held = 1'b1;
            d.wdata = axi_req_i.wdata;
            d.wstrb = axi_req_i.wstrb;
        end
        if (q.axi.bvalid && axi_req_i.bready) begin
            d.axi.bvalid = 1'b0;
        end
        if (q.aw_held && q.w_held && !q.axi.bvalid) begin
            d.aw_held = 1'b0;
            d.w_held = 1'b0;
            d.axi.bvalid = 1'b1;
            d.axi.bresp = RESP_OKAY;
            unique case ({q.awaddr[ADDR_W-1:2], 2'b00})
                REG_FLAGS: begin
                    if (q.wstrb[0]) begin
                        d.flags = q.wdata[7:0];
                    end
                end
                REG_CFG4: begin
                    if (q.wstrb[1]) begin
                        d.bcst_mode = q.wdata[CFG4_BCST_BIT];
                    end
                end
                REG_CFG5: d.tmo = merge16(q.tmo, q.wdata, q.wstrb);
                REG_MASK, REG_GOAL, REG_FETCH, REG_RATE: ;
                default: d.axi.bresp = RESP_SLVERR;
            endcase
        end

        // Register reads
        if (q.axi.rvalid && axi_req_i.rready) begin
            d.axi.rvalid = 1'b0;
        end
        if (axi_req_i.arvalid && q.axi.arready) begin
            unique case ({axi_req_i.araddr[ADDR_W-1:2], 2'b00})
                REG_FLAGS: rd = {24'h000000, q.flags};
                REG_CFG4: rd[CFG4_BCST_BIT] = q.bcst_mode;
                REG_CFG5: rd = {16'h0000, q.tmo};
                REG_MASK: rd = {16'h0000, q.mask};
                REG_GOAL: rd = {16'h0000, q.goal};
                REG_FETCH: rd = {16'h0000, q.fetched};
                REG_RATE: rd = {q.dil_cnt, q.rate};
                default: hit = 1'b0;
            endcase
            d.axi.rvalid = 1'b1;
            d.axi.rdata = rd;
            d.axi.rresp = hit ? RESP_OKAY : RESP_SLVERR;
        end

        // Instructions; their flag updates win over a host write
        if (take) begin
            d.res.done = 1'b1;
            d.res.cond_met = cond_now;
            d.res.target = instr_i.param;
            unique case (instr_i.opcode)
                OP_LOAD_MASK: d.mask = instr_i.param;
                OP_LOAD_GOAL: d.goal = instr_i.param;
                OP_FETCH_WORD: begin
                    d.res.done = 1'b0;
                    d.rdy = 1'b0;
                    d.st = ST_FETCH;
                    d.mreq.valid = 1'b1;
                    d.mreq.addr = instr_i.param;
                end
                OP_RATE_LOAD: begin
                    d.rate = instr_i.param;
                    d.dil_cnt = instr_i.param;
                end
                OP_JUMP_DATA: begin
                    // Caller selects equal (code 1) or flag 0 (code 0)
                    d.res.branch = cond_now
                                 & (q.dil_cnt == 16'h0000);
                    if (q.dil_cnt == 16'h0000) begin
                        d.dil_cnt = q.rate;
                    end else begin
                        d.dil_cnt = q.dil_cnt - 16'h0001;
                    end
                end
                OP_CMP_FRAME: begin
                    d.flags[0] = instr_i.param < frame_time_i;
                    d.flags[1] = instr_i.param == frame_time_i;
                end
                OP_CMP_MSG: begin
                    d.flags[0] = instr_i.param < msg_time_i;
                    d.flags[1] = instr_i.param == msg_time_i;
                end
                OP_FLAG_WRITE: begin
                    // Low byte sets, high byte clears; set wins
                    d.flags = (q.flags & ~instr_i.param[15:8])
                            | instr_i.param[7:0];
                end
                default: ;
            endcase
        end

        // Fetch waits for shared memory; request holds until answered
        if (q.st == ST_FETCH && mem_rsp_i.valid) begin
            d.st = ST_IDLE;
            d.rdy = 1'b1;
            d.mreq.valid = 1'b0;
            d.fetched = mem_rsp_i.data;
            d.flags[0] = mfetch < mgoal;
            d.flags[1] = mfetch == mgoal;
            d.res.done = 1'b1;
            d.res.cond_met = 1'b0;
            d.res.target = q.mreq.addr;
        end

        d.axi.awready = ~d.aw_held;
        d.axi.wready = ~d.w_held;
        d.axi.arready = ~d.axi.rvalid;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            q <= '0;
            q.rdy <= 1'b1;
            q.flags <= FLAGS_RST;
            q.rate <= RATE_RST;
            q.dil_cnt <= RATE_RST;
            q.tmo <= TMO_RST;
        end else begin
            q <= d;
        end
    end

    assign axi_rsp_o = q.axi;
    assign instr_ready_o = q.rdy;
    assign result_o = q.res;
    assign mem_req_o = q.mreq;

    // ********************************************************
    // Checks
    // ********************************************************
    sequence s_fetch_issue;
        take && instr_i.opcode == OP_FETCH_WORD ##1 mem_req_o.valid;
    endsequence

    property p_mask_load;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        take && instr_i.opcode == OP_LOAD_MASK
        |=> q.mask == $past(instr_i.param) && result_o.done;
    endproperty
    a_mask_load: assert property (p_mask_load)
        else $error("mask not loaded");

    property p_goal_load;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        take && instr_i.opcode == OP_LOAD_GOAL
        |=> q.goal == $past(instr_i.param);
    endproperty
    a_goal_load: assert property (p_goal_load)
        else $error("goal not loaded");

    property p_fetch;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        s_fetch_issue |-> mem_req_o.addr == $past(instr_i.param)
            && !instr_ready_o;
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("fetch request wrong");

    property p_fetch_cmp;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        q.st == ST_FETCH && mem_rsp_i.valid
        |=> q.fetched == $past(mem_rsp_i.data)
            && q.flags[0] == $past(mfetch < mgoal)
            && q.flags[1] == $past(mfetch == mgoal) && result_o.done;
    endproperty
    a_fetch_cmp: assert property (p_fetch_cmp)
        else $error("compare flags wrong");

    property p_dil_step;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        take && instr_i.opcode == OP_JUMP_DATA
        |=> q.dil_cnt == ($past(q.dil_cnt) == 16'h0000 ? $past(q.rate)
                          : $past(q.dil_cnt) - 16'h0001);
    endproperty
    a_dil_step: assert property (p_dil_step)
        else $error("dilution count wrong");

    property p_jump;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        take && instr_i.opcode == OP_JUMP_DATA
        |=> result_o.done && result_o.target == $past(instr_i.param)
            && result_o.branch == ($past(cond_now)
                                   && $past(q.dil_cnt) == 16'h0000);
    endproperty
    a_jump: assert property (p_jump)
        else $error("data jump decision wrong");

    property p_rate_load;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        take && instr_i.opcode == OP_RATE_LOAD
        |=> q.rate == $past(instr_i.param)
            && q.dil_cnt == $past(instr_i.param);
    endproperty
    a_rate_load: assert property (p_rate_load)
        else $error("rate not loaded");

    property p_timer_cmp;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        take && instr_i.opcode == OP_CMP_FRAME
        |=> q.flags[0] == $past(instr_i.param < frame_time_i)
            && q.flags[1] == $past(instr_i.param == frame_time_i);
    endproperty
    a_timer_cmp: assert property (p_timer_cmp)
        else $error("timer compare flags wrong");

    property p_const_true;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        take && instr_i.cond[3:0] == COND_TRUE
        |=> result_o.cond_met == !$past(instr_i.cond[COND_INV_BIT]);
    endproperty
    a_const_true: assert property (p_const_true)
        else $error("constant condition wrong");

    property p_flag_cond;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        take && instr_i.cond[3] == 1'b0 && instr_i.opcode != OP_FETCH_WORD
        |=> result_o.cond_met == ($past(q.flags[instr_i.cond[2:0]])
                                  ^ $past(instr_i.cond[COND_INV_BIT]));
    endproperty
    a_flag_cond: assert property (p_flag_cond)
        else $error("flag condition wrong");

endmodule

// [bccd_mem_model.sv]
// Shared memory model answering fetch requests of the block
`timescale 1ns/1ns
module bccd_mem_model
    import bccd_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire bccd_mem_req_t mem_req_i,
    input wire logic [3:0] wait_i,
    output bccd_mem_rsp_t mem_rsp_o
);
    logic [3:0] cnt_q;
    logic done_q;

    always_ff @(posedge clk_sys_i) begin
        // Data toggles when idle, so a stale word never looks valid
        mem_rsp_o.valid <= 1'b0;
        mem_rsp_o.data <= ~mem_rsp_o.data;
        if (!nrst_i) begin
            mem_rsp_o.data <= 16'h5a5a;
            cnt_q <= 4'h0;
            done_q <= 1'b0;
        end else if (!mem_req_i.valid) begin
            cnt_q <= 4'h0;
            done_q <= 1'b0;
        end else if (!done_q && cnt_q == wait_i) begin
            mem_rsp_o <= '{1'b1, mem_req_i.addr ^ 16'hf00f};
            done_q <= 1'b1;
        end else if (!done_q) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

// [tb.sv]
// Self-checking bench for the condition and data-compare block
`timescale 1ns/1ns
module tb;
    import bccd_pkg::*;
    logic clk_sys_i;
    logic nrst_i;
    bccd_axi_req_t aq;
    bccd_axi_rsp_t ar;
    bccd_instr_t ins;
    logic rdy;
    bccd_result_t res;
    bccd_mem_req_t mq;
    bccd_mem_rsp_t mr;
    bccd_msg_stat_t ms;
    logic [15:0] ft;
    logic [15:0] mt;
    logic [3:0] dly;
    int bad_count;
    int check_count;

    bccd_core i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .axi_req_i(aq), .axi_rsp_o(ar), .instr_i(ins),
        .instr_ready_o(rdy), .result_o(res), .mem_req_o(mq),
        .mem_rsp_i(mr), .msg_stat_i(ms), .frame_time_i(ft),
        .msg_time_i(mt));
    bccd_mem_model i_mem (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .mem_req_i(mq), .wait_i(dly), .mem_rsp_o(mr));

    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    // ********************
    // Bus and check tasks
    // ********************
    task automatic test_done();
        $display("TB: checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded wait: a hang ends the run
    task automatic tick(inout int n);
        @(posedge clk_sys_i);
        n++;
        if (n > 200) begin
            bad_count++;
            $display("BAD %0t wait limit", $time);
            test_done();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        int n = 0;
        @(posedge clk_sys_i);
        aq.awvalid <= 1'b1;
        aq.awaddr <= a;
        aq.wvalid <= 1'b1;
        aq.wdata <= d;
        aq.bready <= 1'b1;
        do begin
            tick(n);
            if (ar.awready) aq.awvalid <= 1'b0;
            if (ar.wready) aq.wvalid <= 1'b0;
        end while (!ar.bvalid);
        aq.bready <= 1'b0;
        chk(32'(ar.bresp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
            input logic [1:0] er);
        int n = 0;
        @(posedge clk_sys_i);
        aq.arvalid <= 1'b1;
        aq.araddr <= a;
        aq.rready <= 1'b1;
        do begin
            tick(n);
            if (ar.arready) aq.arvalid <= 1'b0;
        end while (!ar.rvalid);
        aq.rready <= 1'b0;
        chk(ar.rdata, ed);
        chk(32'(ar.rresp), 32'(er));
    endtask

    task automatic op(input logic [4:0] o, input logic [4:0] c,
            input logic [15:0] p);
        int n = 0;
        @(posedge clk_sys_i);
        ins <= '{1'b1, o, c, p};
        do tick(n); while (!rdy);
        ins.valid <= 1'b0;
        do tick(n); while (!res.done);
    endtask

    task automatic jd(input logic [4:0] c, input logic e);
        op(OP_JUMP_DATA, c, 16'h0802);
        chk(32'(res.branch), 32'(e));
    endtask

    // ********************
    // Scenarios
    // ********************
    task automatic t_flags();
        logic [7:0] v = 8'ha5;
        rd(8'h1c, 32'h0, RESP_SLVERR); // Unmapped place
        wr(8'h1c, 32'h1, RESP_SLVERR);
        rd(REG_RATE, 32'h0, RESP_OKAY);
        jd(5'h0f, 1'b1);
        jd(5'h0f, 1'b1);
        wr(REG_FLAGS, 32'h0000_00a5, RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            jd(5'(i), v[i]);
            jd(5'(i) | 5'h10, ~v[i]);
        end
        op(OP_FLAG_WRITE, 5'h0f, 16'h0f5a);
        rd(REG_FLAGS, 32'h0000_00fa, RESP_OKAY);
    endtask

    task automatic t_compare();
        dly <= 4'd3;
        op(OP_LOAD_MASK, 5'h0f, 16'h07ff);
        op(OP_LOAD_GOAL, 5'h0f, 16'hf808);
        op(OP_FETCH_WORD, 5'h0f, 16'h1007);
        chk(32'(res.target), 32'h1007);
        rd(REG_FETCH, 32'h0000_e008, RESP_OKAY);
        rd(REG_MASK, 32'h0000_07ff, RESP_OKAY);
        rd(REG_GOAL, 32'h0000_f808, RESP_OKAY);
        jd(5'h01, 1'b1);
        jd(5'h00, 1'b0);
        dly <= 4'd0;
        op(OP_LOAD_GOAL, 5'h0f, 16'h0009);
        op(OP_FETCH_WORD, 5'h0f, 16'h1007);
        jd(5'h00, 1'b1);
        jd(5'h01, 1'b0);
        op(OP_LOAD_GOAL, 5'h0f, 16'h0007);
        op(OP_FETCH_WORD, 5'h0f, 16'h1007);
        jd(5'h00, 1'b0);
    endtask

    task automatic t_dilute();
        op(OP_RATE_LOAD, 5'h0f, 16'h0002);
        rd(REG_RATE, 32'h0002_0002, RESP_OKAY);
        jd(5'h0f, 1'b0);
        chk(32'(res.cond_met), 32'h1);
        jd(5'h0f, 1'b0);
        rd(REG_RATE, 32'h0000_0002, RESP_OKAY);
        jd(5'h0f, 1'b1);
        rd(REG_RATE, 32'h0002_0002, RESP_OKAY);
        op(OP_RATE_LOAD, 5'h0f, 16'h0001);
        jd(5'h0f, 1'b0);
        jd(5'h1f, 1'b0);
        chk(32'(res.cond_met), 32'h0);
        jd(5'h0f, 1'b0);
        jd(5'h0f, 1'b1);
        op(OP_RATE_LOAD, 5'h0f, 16'h0000);
    endtask

    task automatic t_timer();
        op(OP_CMP_FRAME, 5'h0f, 16'd50);
        jd(5'h00, 1'b1);
        jd(5'h01, 1'b0);
        op(OP_CMP_FRAME, 5'h0f, 16'd100);
        jd(5'h10, 1'b1);
        jd(5'h01, 1'b1);
        op(OP_CMP_MSG, 5'h0f, 16'd6);
        jd(5'h00, 1'b1);
    endtask

    task automatic t_status();
        wr(REG_CFG5, 32'd10, RESP_OKAY);
        rd(REG_CFG5, 32'h0000_000a, RESP_OKAY);
        ms.rsp_time <= 16'd11;
        jd(5'h08, 1'b1);
        ms.rsp_time <= 16'd10;
        jd(5'h08, 1'b0);
        ms.err_parity <= 1'b1;
        jd(5'h09, 1'b1);
        ms.err_parity <= 1'b0;
        ms.good_data <= 1'b1;
        jd(5'h19, 1'b1);
        jd(5'h0a, 1'b1);
        ms.stat_word <= 16'h0008;
        jd(5'h0b, 1'b1);
        ms.ctrl_word <= 16'h1000;
        jd(5'h0b, 1'b0);
        ms.stat_word <= 16'h0000;
        ms.ctrl_word <= 16'h0020;
        jd(5'h0b, 1'b1);
        wr(REG_CFG4, 32'h0000_0800, RESP_OKAY);
        rd(REG_CFG4, 32'h0000_0800, RESP_OKAY);
        jd(5'h0b, 1'b0);
        ms.err_format <= 1'b1;
        jd(5'h0c, 1'b1);
        ms.err_format <= 1'b0;
        ms.no_rsp <= 1'b1;
        jd(5'h0c, 1'b1);
        jd(5'h08, 1'b1);
        ms.retries <= 2'd1;
        jd(5'h0d, 1'b1);
        jd(5'h0e, 1'b0);
        ms.retries <= 2'd2;
        jd(5'h0e, 1'b1);
        jd(5'h1d, 1'b1);
        jd(5'h0f, 1'b1);
        jd(5'h1f, 1'b0);
    endtask

    initial begin
        nrst_i = 1'b0;
        aq = '0;
        aq.wstrb = 4'hf;
        ins = '0;
        ms = '0;
        ft = 16'd100;
        mt = 16'd7;
        dly = 4'd0;
        bad_count = 0;
        check_count = 0;
        repeat (2) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        t_flags();
        t_compare();
        t_dilute();
        t_timer();
        t_status();
        test_done();
    end
endmodule
